// ==== design/rfrb_pkg.sv ====
/*
 * Constants, types and address decode of the receiver feature register bank.
 * Assumes a serial control port front end that delivers whole byte accesses.
 */
// Functional notes
// - features bit 0 enables the indexed channel's over-range pin; resets set.
// - output-assign bit 0 routes converter A (0) or B (1); channel B resets to 1.
// - initial gain is 15 bits: low byte, then bits 14:8; top bit unused.
// - initial phase is 13 bits: low byte, then bits 12:8; three bits unused.
// - in-phase initial DC is 14 bits: low byte, then bits 13:8.
// - quadrature initial DC is 14 bits, low byte in its own register first.
// - a set force bit applies the stored initial value instead of the estimate.
// - a set freeze bit halts estimation and keeps applying the last value.
// - requantizer mode field: 00 low-pass, 01 high-pass, 1x band-pass.
// - next-sync-only aligns divider to first sync, then clears divider sync enable.

package rfrb_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int ADDR_W = 13;
	localparam int NREG = 19;
	localparam logic [4:0] NO_REG = 5'h1F;
	localparam logic [12:0] A_SIGNATURE = 13'h0024;
	localparam logic [12:0] A_FEATURES = 13'h002A;
	localparam logic [12:0] A_ASSIGN = 13'h002E;
	localparam logic [12:0] A_SYNC = 13'h0100;
	localparam logic [12:0] A_GAIN_HI = 13'h0117;
	localparam logic [12:0] A_PHASE_HI = 13'h0119;
	localparam logic [12:0] A_DCI_HI = 13'h011B;
	localparam logic [12:0] A_DCQ_LO = 13'h011C;
	localparam logic [12:0] A_REQUANT = 13'h011E;

	// index of each shared register in the state array
	localparam logic [4:0] I_PATT1_HI = 5'h00;
	localparam logic [4:0] I_PATT2_LO = 5'h01;
	localparam logic [4:0] I_PATT2_HI = 5'h02;
	localparam logic [4:0] I_SYNC = 5'h03;
	localparam logic [4:0] I_USER_CTL_TWO = 5'h04;
	localparam logic [4:0] I_CORR_CTL0 = 5'h05;
	localparam logic [4:0] I_CORR_CTL1 = 5'h06;
	localparam logic [4:0] I_BW_GAIN = 5'h07;
	localparam logic [4:0] I_BW_PHASE = 5'h08;
	localparam logic [4:0] I_BW_DC = 5'h09;
	localparam logic [4:0] I_GAIN_LO = 5'h0A;
	localparam logic [4:0] I_GAIN_HI = 5'h0B;
	localparam logic [4:0] I_PHASE_LO = 5'h0C;
	localparam logic [4:0] I_PHASE_HI = 5'h0D;
	localparam logic [4:0] I_DCI_LO = 5'h0E;
	localparam logic [4:0] I_DCI_HI = 5'h0F;
	localparam logic [4:0] I_DCQ_LO = 5'h10;
	localparam logic [4:0] I_DCQ_HI = 5'h11;
	localparam logic [4:0] I_REQUANT = 5'h12;

	// writable bits and reset values, index 18 first
	localparam logic [NREG-1:0][7:0] REG_MASK = {8'h07, 8'h3F, 8'hFF, 8'h3F, 8'hFF,
		8'h1F, 8'hFF, 8'h7F, 8'hFF, 8'h1F, 8'h1F, 8'h1F, 8'h07, 8'h3F, 8'h8D, 8'h07,
		8'hFF, 8'hFF, 8'hFF};
	localparam logic [NREG-1:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h88, 8'h01,
		8'h00, 8'h00, 8'h00};
	localparam logic [1:0] OR_OE_RESET = 2'h3;
	localparam logic [1:0] ASSIGN_RESET = 2'h2;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int F_MSYNC = 0;
	localparam int F_DSYNC = 1;
	localparam int F_NEXT = 2;
	localparam int F_SDIO = 0;
	localparam int F_RUN = 2;
	localparam int F_DET = 3;
	localparam int F_OE_PIN = 7;
	localparam int F_FRZ = 3;
	localparam int F_REQUANT_EN = 0;

	typedef enum logic [1:0] {
		RFRB_LOWPASS,
		RFRB_HIGHPASS,
		RFRB_BANDPASS
	} rfrb_shaping_mode_t;

	typedef struct packed {
		logic [14:0] gain;
		logic [12:0] phase;
		logic [13:0] dc_i;
		logic [13:0] dc_q;
	} rfrb_corr_t;

	typedef struct packed {
		logic [NREG-1:0][7:0] regs;
		logic [1:0] or_oe;
		logic [1:0] assign_b;
		logic [1:0] or_pin;
		rfrb_corr_t applied;
		logic [7:0] rdata;
		logic div_sync;
	} rfrb_state_t;

	function automatic logic [4:0] rfrb_index(input logic [12:0] a);
		case (a)
			13'h001A: rfrb_index = I_PATT1_HI;
			13'h001B: rfrb_index = I_PATT2_LO;
			13'h001C: rfrb_index = I_PATT2_HI;
			13'h0100: rfrb_index = I_SYNC;
			13'h0101: rfrb_index = I_USER_CTL_TWO;
			13'h0110: rfrb_index = I_CORR_CTL0;
			13'h0111: rfrb_index = I_CORR_CTL1;
			13'h0112: rfrb_index = I_BW_GAIN;
			13'h0113: rfrb_index = I_BW_PHASE;
			13'h0114: rfrb_index = I_BW_DC;
			13'h0116: rfrb_index = I_GAIN_LO;
			13'h0117: rfrb_index = I_GAIN_HI;
			13'h0118: rfrb_index = I_PHASE_LO;
			13'h0119: rfrb_index = I_PHASE_HI;
			13'h011A: rfrb_index = I_DCI_LO;
			13'h011B: rfrb_index = I_DCI_HI;
			13'h011C: rfrb_index = I_DCQ_LO;
			13'h011D: rfrb_index = I_DCQ_HI;
			13'h011E: rfrb_index = I_REQUANT;
			default: rfrb_index = NO_REG;
		endcase
	endfunction

endpackage

// ==== design/rfrb_bank.sv ====
/*
 * Receiver feature register bank: pattern, self-test, over-range, output
 * assignment, divider sync, slow clock oscillator, I/Q correction and
 * requantizer controls.
 * Assumes the serial port front end presents one byte access per strobe,
 * synchronous to mclk_in, and that the channel index comes from elsewhere.
 */
`timescale 1ns/1ps

module rfrb_bank (
	// clock and reset
	input wire logic mclk_in,
	input wire logic arst_n_in,
	// register access from the serial port
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [rfrb_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [1:0] chan_index_in,
	output logic [7:0] reg_rdata_out,
	// self-test and patterns
	input wire logic [7:0] selftest_sig_in,
	output logic [7:0] user_pattern1_high_out,
	output logic [15:0] user_pattern2_out,
	// over-range and output routing
	input wire logic [1:0] over_range_raw_in,
	output logic [1:0] over_range_pin_out,
	output logic [1:0] conv_sel_b_out,
	// divider sync
	input wire logic sync_pulse_in,
	output logic div_sync_out,
	// pins and slow clock oscillator
	input wire logic output_enable_pin_n_in,
	input wire logic low_rate_in,
	output logic data_drive_en_out,
	output logic slow_clock_oscillator_run_out,
	output logic sdio_pulldown_en_out,
	// iq error correction
	input wire rfrb_pkg::rfrb_corr_t est_in,
	input wire logic est_valid_in,
	output rfrb_pkg::rfrb_corr_t corr_out,
	output logic [2:0] corr_en_out,
	output logic [2:0] est_run_out,
	output logic [4:0] gain_loop_exponent_out,
	output logic [4:0] phase_loop_exponent_out,
	output logic [4:0] dc_loop_exponent_out,
	// noise shaping requantizer
	output logic requantizer_en_out,
	output rfrb_pkg::rfrb_shaping_mode_t requantizer_mode_out
);

	// ************************************************************
	// state
	// ************************************************************
	rfrb_pkg::rfrb_state_t s_q;
	rfrb_pkg::rfrb_state_t s_d;
	logic [4:0] wr_idx;
	logic [4:0] rd_idx;
	logic [2:0] en;
	logic [2:0] frz;
	logic [2:0] frc;
	rfrb_pkg::rfrb_corr_t init;

	// disable wins, then force, then freeze, then a fresh estimate
	function automatic logic [14:0] pick(input logic e, input logic f, input logic z,
		input logic v, input logic [14:0] ini, input logic [14:0] est, input logic [14:0] hold);
		if (!e) begin
			pick = 15'h0000;
		end else if (f) begin
			pick = ini;
		end else if (z || !v) begin
			pick = hold;
		end else begin
			pick = est;
		end
	endfunction

	assign wr_idx = rfrb_pkg::rfrb_index(reg_addr_in);
	assign rd_idx = rfrb_pkg::rfrb_index(reg_addr_in);
	assign en = s_q.regs[rfrb_pkg::I_CORR_CTL0][2:0];
	assign frz = s_q.regs[rfrb_pkg::I_CORR_CTL0][rfrb_pkg::F_FRZ+:3];
	assign frc = s_q.regs[rfrb_pkg::I_CORR_CTL1][2:0];
	assign init.gain = {s_q.regs[rfrb_pkg::I_GAIN_HI][6:0], s_q.regs[rfrb_pkg::I_GAIN_LO]};
	assign init.phase = {s_q.regs[rfrb_pkg::I_PHASE_HI][4:0], s_q.regs[rfrb_pkg::I_PHASE_LO]};
	assign init.dc_i = {s_q.regs[rfrb_pkg::I_DCI_HI][5:0], s_q.regs[rfrb_pkg::I_DCI_LO]};
	assign init.dc_q = {s_q.regs[rfrb_pkg::I_DCQ_HI][5:0], s_q.regs[rfrb_pkg::I_DCQ_LO]};

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [1:0] rd_chan;
		logic sync_fire;
		rd_chan = chan_index_in[0] ? 2'h1 : 2'h2;
		s_d = s_q;
		sync_fire = sync_pulse_in && s_q.regs[rfrb_pkg::I_SYNC][rfrb_pkg::F_MSYNC]
			&& s_q.regs[rfrb_pkg::I_SYNC][rfrb_pkg::F_DSYNC];
		s_d.div_sync = sync_fire;
		// one-shot mode drops the enable after use; a write in the same cycle wins
		if (sync_fire && s_q.regs[rfrb_pkg::I_SYNC][rfrb_pkg::F_NEXT]) begin
			s_d.regs[rfrb_pkg::I_SYNC][rfrb_pkg::F_DSYNC] = 1'b0;
		end
		if (reg_wr_in) begin
			if (wr_idx != rfrb_pkg::NO_REG) begin
				s_d.regs[wr_idx] = reg_wdata_in & rfrb_pkg::REG_MASK[wr_idx];
			end
			// local registers land on every indexed channel
			for (int c = 0; c < 2; c++) begin
				if (chan_index_in[c] && reg_addr_in == rfrb_pkg::A_FEATURES) begin
					s_d.or_oe[c] = reg_wdata_in[0];
				end
				if (chan_index_in[c] && reg_addr_in == rfrb_pkg::A_ASSIGN) begin
					s_d.assign_b[c] = reg_wdata_in[0];
				end
			end
		end
		s_d.or_pin = over_range_raw_in & s_q.or_oe;
		// reads with no channel indexed show channel B
		s_d.rdata = 8'h00;
		if (reg_rd_in) begin
			if (rd_idx != rfrb_pkg::NO_REG) begin
				s_d.rdata = s_q.regs[rd_idx];
			end else if (reg_addr_in == rfrb_pkg::A_SIGNATURE) begin
				s_d.rdata = selftest_sig_in;
			end else if (reg_addr_in == rfrb_pkg::A_FEATURES) begin
				s_d.rdata = {7'h00, |(s_q.or_oe & rd_chan)};
			end else if (reg_addr_in == rfrb_pkg::A_ASSIGN) begin
				s_d.rdata = {7'h00, |(s_q.assign_b & rd_chan)};
			end
		end
		s_d.applied.gain = pick(en[0], frc[0], frz[0], est_valid_in, init.gain,
			est_in.gain, s_q.applied.gain);
		s_d.applied.phase = 13'(pick(en[1], frc[1], frz[1], est_valid_in,
			{2'h0, init.phase}, {2'h0, est_in.phase}, {2'h0, s_q.applied.phase}));
		s_d.applied.dc_i = 14'(pick(en[2], frc[2], frz[2], est_valid_in,
			{1'h0, init.dc_i}, {1'h0, est_in.dc_i}, {1'h0, s_q.applied.dc_i}));
		s_d.applied.dc_q = 14'(pick(en[2], frc[2], frz[2], est_valid_in,
			{1'h0, init.dc_q}, {1'h0, est_in.dc_q}, {1'h0, s_q.applied.dc_q}));
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_q <= '0;
			s_q.regs <= rfrb_pkg::REG_RESET;
			s_q.or_oe <= rfrb_pkg::OR_OE_RESET;
			s_q.assign_b <= rfrb_pkg::ASSIGN_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign reg_rdata_out = s_q.rdata;
	assign user_pattern1_high_out = s_q.regs[rfrb_pkg::I_PATT1_HI];
	assign user_pattern2_out = {s_q.regs[rfrb_pkg::I_PATT2_HI], s_q.regs[rfrb_pkg::I_PATT2_LO]};
	assign over_range_pin_out = s_q.or_pin;
	assign conv_sel_b_out = s_q.assign_b;
	assign div_sync_out = s_q.div_sync;
	// with the pin disabled the drivers stay on regardless of its level
	assign data_drive_en_out = !(s_q.regs[rfrb_pkg::I_USER_CTL_TWO][rfrb_pkg::F_OE_PIN] && output_enable_pin_n_in);
	assign slow_clock_oscillator_run_out = s_q.regs[rfrb_pkg::I_USER_CTL_TWO][rfrb_pkg::F_RUN]
		|| (s_q.regs[rfrb_pkg::I_USER_CTL_TWO][rfrb_pkg::F_DET] && low_rate_in);
	assign sdio_pulldown_en_out = !s_q.regs[rfrb_pkg::I_USER_CTL_TWO][rfrb_pkg::F_SDIO];
	assign corr_out = s_q.applied;
	assign corr_en_out = en;
	assign est_run_out = en & ~frz & ~frc;
	assign gain_loop_exponent_out = s_q.regs[rfrb_pkg::I_BW_GAIN][4:0];
	assign phase_loop_exponent_out = s_q.regs[rfrb_pkg::I_BW_PHASE][4:0];
	assign dc_loop_exponent_out = s_q.regs[rfrb_pkg::I_BW_DC][4:0];
	assign requantizer_en_out = s_q.regs[rfrb_pkg::I_REQUANT][rfrb_pkg::F_REQUANT_EN];
	always_comb begin
		case (s_q.regs[rfrb_pkg::I_REQUANT][2:1])
			2'b00: requantizer_mode_out = rfrb_pkg::RFRB_LOWPASS;
			2'b01: requantizer_mode_out = rfrb_pkg::RFRB_HIGHPASS;
			default: requantizer_mode_out = rfrb_pkg::RFRB_BANDPASS;
		endcase
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);

	or_disable_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_FEATURES
		&& chan_index_in[0] && !reg_wdata_in[0] |=> ##1 !over_range_pin_out[0])
		else $error("over-range pin not disabled");
	conv_assign_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_ASSIGN
		&& chan_index_in[1] |=> conv_sel_b_out[1] == $past(reg_wdata_in[0]))
		else $error("output assignment not taken");
	gain_high_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_GAIN_HI
		|=> init.gain[14:8] == $past(reg_wdata_in[6:0]))
		else $error("initial gain high bits wrong");
	phase_high_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_PHASE_HI
		|=> init.phase[12:8] == $past(reg_wdata_in[4:0]))
		else $error("initial phase high bits wrong");
	dc_i_high_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_DCI_HI
		|=> init.dc_i[13:8] == $past(reg_wdata_in[5:0]))
		else $error("initial dc i high bits wrong");
	dc_q_low_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_DCQ_LO
		|=> init.dc_q[7:0] == $past(reg_wdata_in))
		else $error("initial dc q low byte wrong");
	force_gain_a: assert property (en[0] && frc[0] |=> corr_out.gain == $past(init.gain))
		else $error("forced gain not applied");
	freeze_phase_a: assert property (en[1] && frz[1] && !frc[1] |=> $stable(corr_out.phase))
		else $error("frozen phase changed");
	shaping_mode_a: assert property (reg_wr_in && reg_addr_in == rfrb_pkg::A_REQUANT && reg_wdata_in[2]
		|=> requantizer_mode_out == rfrb_pkg::RFRB_BANDPASS)
		else $error("band-pass mode not selected");
	next_sync_a: assert property (sync_pulse_in && s_q.regs[rfrb_pkg::I_SYNC] == 8'h07 && !reg_wr_in
		|=> div_sync_out && !s_q.regs[rfrb_pkg::I_SYNC][rfrb_pkg::F_DSYNC] ##1 !div_sync_out)
		else $error("one-shot divider sync wrong");
	open_bits_a: assert property (reg_rd_in && reg_addr_in == rfrb_pkg::A_GAIN_HI
		|=> !reg_rdata_out[7])
		else $error("unused bit read as one");

	force_gain_c: cover property (en[0] && frc[0] ##1 corr_out.gain != 15'h0000);
	one_shot_c: cover property (div_sync_out && !s_q.regs[rfrb_pkg::I_SYNC][rfrb_pkg::F_DSYNC]);
	signature_c: cover property (reg_rd_in && reg_addr_in == rfrb_pkg::A_SIGNATURE);
	bandpass_c: cover property (requantizer_en_out && requantizer_mode_out == rfrb_pkg::RFRB_BANDPASS);

endmodule // rfrb_bank

// ==== tb/receiver_feature_register_bank_tb.sv ====
/*
 * Self-checking bench for the receiver feature register bank.
 * Assumes the byte-wide strobe register port and fixed latencies: one cycle, two from over-range enable and correction control writes.
 */
`timescale 1ns/1ps

module receiver_feature_register_bank_tb;
	// ************************************************************
	// stimulus and response signals
	// ************************************************************
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [12:0] reg_addr_in = 13'h0000;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [1:0] chan_index_in = 2'h3;
	logic [7:0] selftest_sig_in = 8'h5A;
	logic [1:0] over_range_raw_in = 2'h3;
	logic sync_pulse_in = 1'b0;
	logic output_enable_pin_n_in = 1'b0;
	logic low_rate_in = 1'b0;
	rfrb_pkg::rfrb_corr_t est_in = '0;
	logic est_valid_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic [7:0] user_pattern1_high_out;
	logic [15:0] user_pattern2_out;
	logic [1:0] over_range_pin_out;
	logic [1:0] conv_sel_b_out;
	logic div_sync_out;
	logic data_drive_en_out;
	logic slow_clock_oscillator_run_out;
	logic sdio_pulldown_en_out;
	rfrb_pkg::rfrb_corr_t corr_out;
	logic [2:0] corr_en_out;
	logic [2:0] est_run_out;
	logic [4:0] gain_loop_exponent_out;
	logic [4:0] phase_loop_exponent_out;
	logic [4:0] dc_loop_exponent_out;
	logic requantizer_en_out;
	rfrb_pkg::rfrb_shaping_mode_t requantizer_mode_out;
	logic [2:0] pin_ctl;
	logic [14:0] loop_exp;
	int err_total = 0;
	int total_checks = 0;
	logic [12:0] rst_addr [10] = '{13'h01A, 13'h01C, 13'h02A, 13'h02E, 13'h100, 13'h101, 13'h112, 13'h113,
		13'h114, 13'h11E};
	logic [7:0] rst_val [10] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h88, 8'h02, 8'h02, 8'h02, 8'h00};

	rfrb_bank rfrb_bank_i (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.chan_index_in(chan_index_in), .reg_rdata_out(reg_rdata_out), .selftest_sig_in(selftest_sig_in),
		.user_pattern1_high_out(user_pattern1_high_out), .user_pattern2_out(user_pattern2_out),
		.over_range_raw_in(over_range_raw_in), .over_range_pin_out(over_range_pin_out),
		.conv_sel_b_out(conv_sel_b_out), .sync_pulse_in(sync_pulse_in), .div_sync_out(div_sync_out),
		.output_enable_pin_n_in(output_enable_pin_n_in), .low_rate_in(low_rate_in),
		.data_drive_en_out(data_drive_en_out), .slow_clock_oscillator_run_out(slow_clock_oscillator_run_out),
		.sdio_pulldown_en_out(sdio_pulldown_en_out), .est_in(est_in), .est_valid_in(est_valid_in),
		.corr_out(corr_out), .corr_en_out(corr_en_out), .est_run_out(est_run_out),
		.gain_loop_exponent_out(gain_loop_exponent_out), .phase_loop_exponent_out(phase_loop_exponent_out),
		.dc_loop_exponent_out(dc_loop_exponent_out), .requantizer_en_out(requantizer_en_out),
		.requantizer_mode_out(requantizer_mode_out));

	// grouped views so one compare covers each related set of outputs
	assign pin_ctl = {data_drive_en_out, slow_clock_oscillator_run_out, sdio_pulldown_en_out};
	assign loop_exp = {gain_loop_exponent_out, phase_loop_exponent_out, dc_loop_exponent_out};

	initial begin
		forever #12.5 mclk_in = ~mclk_in;
	end

	// ************************************************************
	// access and compare tasks
	// ************************************************************
	task automatic stop_test();
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// inputs change on the falling edge, so the design samples settled values
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		@(negedge mclk_in);
		reg_wr_in = 1'b0;
	endtask

	task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
		@(negedge mclk_in);
		reg_rd_in = 1'b1;
		reg_addr_in = a;
		@(negedge mclk_in);
		reg_rd_in = 1'b0;
		chk_byte(reg_rdata_out, exp, "register read");
	endtask

	// hang guard: the run is far shorter than this bound
	initial begin
		repeat (5000) @(posedge mclk_in);
		err_total++;
		$display("mismatch %0t run did not finish", $time);
		stop_test();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		repeat (5) @(posedge mclk_in);
		@(negedge mclk_in);
		arst_n_in = 1'b1;
		chan_index_in = 2'h1;
		output_enable_pin_n_in = 1'b1;
		low_rate_in = 1'b1;
		chk_val({14'h0, conv_sel_b_out}, 16'h0002, "assign reset");
		foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i]);
		chk_val({13'h0, pin_ctl}, 16'h0003, "pin controls at reset");
		// field widths and unused bits
		wr(13'h117, 8'hFF);
		rd_chk(13'h117, 8'h7F);
		wr(13'h119, 8'hFF);
		rd_chk(13'h119, 8'h1F);
		wr(13'h11B, 8'hFF);
		rd_chk(13'h11B, 8'h3F);
		wr(13'h11C, 8'hFF);
		rd_chk(13'h11C, 8'hFF);
		wr(13'h101, 8'hFF);
		rd_chk(13'h101, 8'h8D);
		chk_val({13'h0, pin_ctl}, 16'h0002, "pin controls all set");
		wr(13'h101, 8'h08);
		chk_val({13'h0, pin_ctl}, 16'h0007, "pin controls detect only");
		low_rate_in = 1'b0;
		@(negedge mclk_in);
		chk_val({13'h0, pin_ctl}, 16'h0005, "pin controls normal rate");
		wr(13'h115, 8'hFF);
		rd_chk(13'h115, 8'h00);
		wr(13'h024, 8'h00);
		rd_chk(13'h024, 8'h5A);
		wr(13'h01A, 8'hC3);
		wr(13'h01B, 8'h5A);
		wr(13'h01C, 8'hA5);
		chk_val({8'h0, user_pattern1_high_out}, 16'h00C3, "pattern 1 high");
		chk_val(user_pattern2_out, 16'hA55A, "pattern 2");
		rd_chk(13'h01B, 8'h5A);
		wr(13'h112, 8'hFF);
		wr(13'h113, 8'h03);
		wr(13'h114, 8'h2A);
		chk_val({1'b0, loop_exp}, 16'h7C6A, "loop exponents");
		// channel-local over-range enable and output assignment
		wr(13'h02A, 8'h00);
		@(negedge mclk_in);
		chk_val({14'h0, over_range_pin_out}, 16'h0002, "over-range pins");
		rd_chk(13'h02A, 8'h00);
		wr(13'h02E, 8'hFF);
		chk_val({14'h0, conv_sel_b_out}, 16'h0003, "assign");
		chan_index_in = 2'h2;
		rd_chk(13'h02A, 8'h01);
		rd_chk(13'h02E, 8'h01);
		// requantizer modes
		for (int m = 0; m < 4; m++) begin
			wr(13'h11E, {5'h1F, m[1:0], 1'b1});
			chk_val({14'h0, requantizer_mode_out}, (m > 1) ? 16'h0002 : 16'(m), "shaping mode");
			chk_val({15'h0, requantizer_en_out}, 16'h0001, "requantizer on");
		end
		wr(13'h11E, 8'h04);
		chk_val({13'h0, requantizer_en_out, requantizer_mode_out}, 16'h0002, "requantizer off");
		// forced gain, then estimate, then freeze
		wr(13'h116, 8'h34);
		wr(13'h117, 8'h12);
		wr(13'h110, 8'h01);
		wr(13'h111, 8'h01);
		repeat (2) @(negedge mclk_in);
		chk_val({1'b0, corr_out.gain}, 16'h1234, "forced gain");
		est_in.gain = 15'h0ABC;
		est_valid_in = 1'b1;
		wr(13'h111, 8'h00);
		repeat (2) @(negedge mclk_in);
		chk_val({1'b0, corr_out.gain}, 16'h0ABC, "estimated gain");
		chk_val({13'h0, est_run_out}, 16'h0001, "gain estimation runs");
		wr(13'h110, 8'h09);
		est_in.gain = 15'h0111;
		repeat (3) @(negedge mclk_in);
		chk_val({1'b0, corr_out.gain}, 16'h0ABC, "frozen gain");
		chk_val({15'h0, est_run_out[0]}, 16'h0000, "gain estimation halted");
		// forced phase and dc, then frozen phase
		wr(13'h118, 8'hC3);
		wr(13'h11D, 8'h3F);
		wr(13'h11C, 8'hA5);
		wr(13'h110, 8'h0F);
		wr(13'h111, 8'h06);
		repeat (2) @(negedge mclk_in);
		chk_val({3'h0, corr_out.phase}, 16'h1FC3, "forced phase");
		chk_val({2'h0, corr_out.dc_i}, 16'h3F00, "forced dc i");
		chk_val({2'h0, corr_out.dc_q}, 16'h3FA5, "forced dc q");
		chk_val({10'h0, corr_en_out, est_run_out}, 16'h0038, "correction enables");
		wr(13'h110, 8'h17);
		wr(13'h111, 8'h04);
		repeat (2) @(negedge mclk_in);
		chk_val({3'h0, corr_out.phase}, 16'h1FC3, "frozen phase");
		chk_val({1'b0, corr_out.gain}, 16'h0111, "gain follows estimate");
		// one-shot divider sync
		wr(13'h100, 8'h07);
		sync_pulse_in = 1'b1;
		@(negedge mclk_in);
		sync_pulse_in = 1'b0;
		chk_val({15'h0, div_sync_out}, 16'h0001, "first sync");
		rd_chk(13'h100, 8'h05);
		sync_pulse_in = 1'b1;
		@(negedge mclk_in);
		sync_pulse_in = 1'b0;
		chk_val({15'h0, div_sync_out}, 16'h0000, "later sync ignored");
		// continuous sync keeps its enable; master off blocks all pulses
		wr(13'h100, 8'h03);
		sync_pulse_in = 1'b1;
		repeat (2) begin
			@(negedge mclk_in);
			chk_val({15'h0, div_sync_out}, 16'h0001, "continuous sync");
		end
		sync_pulse_in = 1'b0;
		rd_chk(13'h100, 8'h03);
		wr(13'h100, 8'h02);
		sync_pulse_in = 1'b1;
		@(negedge mclk_in);
		sync_pulse_in = 1'b0;
		chk_val({15'h0, div_sync_out}, 16'h0000, "master sync off");
		stop_test();
	end
endmodule // receiver_feature_register_bank_tb
